// ==== design/ulm_defs.vh ====
// register map, field positions, reset values and timing counts of the line/modem status block
`ifndef ULM_DEFS_VH
`define ULM_DEFS_VH

// byte addresses on the register bus
`define ULM_RXBUF_ADDR 32'h5000_1100
`define ULM_CTRL_ADDR 32'h5000_1104
`define ULM_LINE_STATUS_ADDR 32'h5000_1114
`define ULM_MODEM_STATUS_ADDR 32'h5000_1118

// line_status fields
`define ULM_LS_DATA_READY 0
`define ULM_LS_OVERRUN 1
`define ULM_LS_PARITY_ERR 2
`define ULM_LS_FRAMING_ERR 3
`define ULM_LS_BREAK 4

// modem_status fields
`define ULM_MS_CTS_DELTA 0
`define ULM_MS_RING_TRAIL 2
`define ULM_MS_DCD_DELTA 3
`define ULM_MS_CTS 4
`define ULM_MS_RING 6
`define ULM_MS_DCD 7

// control register fields
`define ULM_CTL_FIFO_EN 0
`define ULM_CTL_PARITY_EN 1
`define ULM_CTL_RTS 2
`define ULM_CTL_USER_OUTPUT_ONE 3
`define ULM_CTL_USER_OUTPUT_TWO 4
`define ULM_CTL_LOOP 5
`define ULM_CTL_W 6

// reset values
`define ULM_CTL_RST 6'h00
`define ULM_SYNC_RST 4'hF
`define ULM_FLAG_RST 3'h0

// receiver timing: oversample tick counts within a bit, and core clocks per oversample tick
`define ULM_OS_MID 4'h7
`define ULM_OS_LAST 4'hF
`define ULM_SAMPLE_DIV 11

`endif

// ==== design/ulm_status.v ====
// line and modem status block: receiver, receive fifo, status flags and APB registers
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "ulm_defs.vh"
// ----------------------------------------------------------------
// What this block does
// R1: framing error flag sets when the stop bit samples low.
// R2: after a framing error that is not a break the low stop is taken as the next start bit.
// R3: a detected break also sets framing and parity error flags.
// R4: the parity error flag sets only while parity enable is set, or on a detected break.
// R5: in fifo mode error bits travel with the character and show at the head.
// R6: reading line status clears framing, parity and overrun flags.
// R7: non-fifo: new character over an unread one sets overrun and overwrites.
// R8: fifo mode: character into a full fifo sets overrun and is dropped.
// R9: data ready shows a character is available; clears on read or fifo empty.
// R10: carrier detect status is the inverse of the active-low carrier input.
// R11: in loopback carrier detect status follows user output two.
// R12: ring status is the inverted ring input, or user output one in loopback.
// R13: clear-to-send status is the inverted input, or rts in loopback.
// R14: carrier delta sets on any carrier change, clears on modem status read.
// R15: carrier asserted across reset sets the carrier delta after release.
// R16: in loopback carrier delta records changes of user output two.
// R17: ring trailing flag sets when ring goes inactive; modem status read clears.
// R18: in loopback ring trailing flag sets on user output one falling.
// R19: fifo mode is in effect while the fifo enable bit is one.
// R20: reading line status also clears the break indication flag.
// R21: clear-to-send delta records any change and clears on modem status read.
// R22: reserved bits read zero; clear-on-read keeps events from the same cycle.
// R23: modem inputs are synchronised before feeding status and delta logic.
// ----------------------------------------------------------------
module ulm_status #(
  parameter SAMPLE_DIV = `ULM_SAMPLE_DIV,
  parameter FIFO_AW = 4
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  // serial line and modem inputs, active low
  input wire rxd_in,
  input wire dcd_in_low,
  input wire ring_in_low,
  input wire cts_in_low,
  // modem outputs, active low
  output wire rts_out_low,
  output wire user_user_output_one_low,
  output wire user_user_output_two_low
);

  localparam SEL_NONE = 3'h0;
  localparam SEL_RXBUF = 3'h1;
  localparam SEL_CTRL = 3'h2;
  localparam SEL_LS = 3'h3;
  localparam SEL_MS = 3'h4;
  localparam RX_IDLE = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA = 3'h2;
  localparam RX_PAR = 3'h3;
  localparam RX_STOP = 3'h4;
  localparam RX_BRK = 3'h5;
  localparam DEPTH = 1 << FIFO_AW;
  localparam [31:0] DIV_LAST_W = SAMPLE_DIV - 1;
  localparam [15:0] DIV_LAST = DIV_LAST_W[15:0];

  function [2:0] reg_sel;
    input [31:0] a;
    begin
      case (a)
        `ULM_RXBUF_ADDR: reg_sel = SEL_RXBUF;
        `ULM_CTRL_ADDR: reg_sel = SEL_CTRL;
        `ULM_LINE_STATUS_ADDR: reg_sel = SEL_LS;
        `ULM_MODEM_STATUS_ADDR: reg_sel = SEL_MS;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // order {cts, ring, dcd, rxd}; reset value is the idle/inactive level
  reg [3:0] s1_reg;
  reg [3:0] s2_reg;
  reg [3:0] s3_reg;
  reg [3:0] filt_reg;
  wire [3:0] agree = ~(s2_reg ^ s3_reg);
  wire [3:0] filt_next = (agree & s2_reg) | (~agree & filt_reg);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= `ULM_SYNC_RST;
      s2_reg <= `ULM_SYNC_RST;
      s3_reg <= `ULM_SYNC_RST;
      filt_reg <= `ULM_SYNC_RST;
    end else begin
      s1_reg <= {cts_in_low, ring_in_low, dcd_in_low, rxd_in}; // R23
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next; // R23
    end
  end
  wire rx_line = filt_reg[0];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  reg pready_reg;
  reg [31:0] prdata_reg;
  reg pslverr_reg;
  reg [`ULM_CTL_W-1:0] ctl_reg;

  wire [2:0] sel = reg_sel(paddr);
  wire access = psel & penable;
  wire first = access & ~pready_reg;
  wire done = access & pready_reg;
  wire rd_done = done & ~pwrite;
  wire ctl_wr = done & pwrite & (sel == SEL_CTRL);
  wire ls_read = rd_done & (sel == SEL_LS);
  wire ms_read = rd_done & (sel == SEL_MS);
  wire rb_read = rd_done & (sel == SEL_RXBUF);

  wire fifo_en = ctl_reg[`ULM_CTL_FIFO_EN]; // R19
  wire par_en = ctl_reg[`ULM_CTL_PARITY_EN];
  wire loop = ctl_reg[`ULM_CTL_LOOP];
  // a change of mode empties both holding paths
  wire flush = ctl_wr & (pwdata[`ULM_CTL_FIFO_EN] != fifo_en);

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  reg [15:0] div_reg;
  reg [2:0] rx_st_reg;
  reg [3:0] os_reg;
  reg [2:0] bit_reg;
  reg [7:0] shift_reg;
  reg par_bit_reg;
  reg done_reg;
  reg [2:0] err_reg;
  wire tick = (div_reg == DIV_LAST);
  wire os_end = tick & (os_reg == `ULM_OS_LAST);
  wire stop_bad = ~rx_line;
  wire brk = stop_bad & (shift_reg == 8'h00) & ~(par_en & par_bit_reg);
  wire par_bad = par_en & (^shift_reg ^ par_bit_reg); // R4
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 16'h0000;
      rx_st_reg <= RX_IDLE;
      os_reg <= 4'h0;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      par_bit_reg <= 1'h0;
      done_reg <= 1'h0;
      err_reg <= `ULM_FLAG_RST;
    end else begin
      div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
      done_reg <= 1'h0;
      if (tick) begin
        os_reg <= os_reg + 4'h1;
      end
      case (rx_st_reg)
        RX_IDLE: begin
          os_reg <= 4'h0;
          if (tick & ~rx_line) begin
            rx_st_reg <= RX_START;
          end
        end
        RX_START: begin
          if (tick & (os_reg == `ULM_OS_MID)) begin
            os_reg <= 4'h0;
            bit_reg <= 3'h0;
            rx_st_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (os_end) begin
            shift_reg <= {rx_line, shift_reg[7:1]};
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              rx_st_reg <= par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (os_end) begin
            par_bit_reg <= rx_line;
            rx_st_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (os_end) begin
            done_reg <= 1'h1;
            // {break, framing, parity}
            err_reg <= {brk, stop_bad | brk, par_bad | brk}; // R1 R3
            bit_reg <= 3'h0;
            par_bit_reg <= 1'h0;
            if (brk) begin
              // one character per break: wait for the line to go idle
              rx_st_reg <= RX_BRK;
            end else if (stop_bad) begin
              // the low stop sample acts as the middle of a new start bit
              os_reg <= 4'h0;
              rx_st_reg <= RX_DATA; // R2
            end else begin
              rx_st_reg <= RX_IDLE;
            end
          end
        end
        RX_BRK: begin
          if (rx_line) begin
            rx_st_reg <= RX_IDLE;
          end
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive fifo and holding register
  // ----------------------------------------------------------------
  reg [10:0] mem [0:DEPTH-1];
  reg [FIFO_AW-1:0] wr_ptr_reg;
  reg [FIFO_AW-1:0] rd_ptr_reg;
  reg [FIFO_AW:0] cnt_reg;
  reg [7:0] rbr_reg;
  reg rbr_valid_reg;
  wire [10:0] entry = {err_reg, shift_reg}; // R5
  wire full = (cnt_reg == DEPTH);
  wire push = done_reg & fifo_en & ~full;
  wire pop = rb_read & fifo_en & (cnt_reg != 0);
  wire [FIFO_AW-1:0] rd_ptr_nx = rd_ptr_reg + 1'b1;
  wire reveal_push = push & ((cnt_reg == 0) | (pop & (cnt_reg == 1)));
  wire reveal_pop = pop & (cnt_reg > 1);
  wire [10:0] reveal = reveal_push ? entry : mem[rd_ptr_nx];
  wire ovr_fifo = done_reg & fifo_en & full; // R8
  wire ovr_nf = done_reg & ~fifo_en & rbr_valid_reg & ~rb_read; // R7
  wire nf_load = done_reg & ~fifo_en;
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= entry;
    end
  end
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= {FIFO_AW{1'b0}};
      rd_ptr_reg <= {FIFO_AW{1'b0}};
      cnt_reg <= {(FIFO_AW+1){1'b0}};
      rbr_reg <= 8'h00;
      rbr_valid_reg <= 1'h0;
    end else if (flush) begin
      wr_ptr_reg <= {FIFO_AW{1'b0}};
      rd_ptr_reg <= {FIFO_AW{1'b0}};
      cnt_reg <= {(FIFO_AW+1){1'b0}};
      rbr_valid_reg <= 1'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_nx;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      if (nf_load) begin
        rbr_reg <= shift_reg; // R7
        rbr_valid_reg <= 1'h1;
      end else if (rb_read) begin
        rbr_valid_reg <= 1'h0; // R9
      end
    end
  end

  // ----------------------------------------------------------------
  // line status flags
  // ----------------------------------------------------------------
  reg [2:0] lerr_reg;
  reg ovr_reg;
  // {break, framing, parity} events, at arrival or when revealed at the head
  wire [2:0] err_set = fifo_en ? ((reveal_push | reveal_pop) ? reveal[10:8] : 3'h0) // R5
                               : (nf_load ? err_reg : 3'h0);
  // only the bits actually returned by the read are cleared
  wire [2:0] err_clr = ls_read ? {prdata_reg[`ULM_LS_BREAK], prdata_reg[`ULM_LS_FRAMING_ERR],
                                  prdata_reg[`ULM_LS_PARITY_ERR]} : 3'h0;
  wire ovr_clr = ls_read & prdata_reg[`ULM_LS_OVERRUN];
  wire data_ready = fifo_en ? (cnt_reg != 0) : rbr_valid_reg; // R9

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lerr_reg <= `ULM_FLAG_RST;
      ovr_reg <= 1'h0;
    end else begin
      lerr_reg <= (lerr_reg & ~err_clr) | err_set; // R6 R20 R22
      ovr_reg <= (ovr_reg & ~ovr_clr) | ovr_fifo | ovr_nf; // R6 R22
    end
  end

  // ----------------------------------------------------------------
  // modem status
  // ----------------------------------------------------------------
  wire dcd_now = loop ? ctl_reg[`ULM_CTL_USER_OUTPUT_TWO] : ~filt_reg[1]; // R10 R11
  wire ring_now = loop ? ctl_reg[`ULM_CTL_USER_OUTPUT_ONE] : ~filt_reg[2]; // R12
  wire cts_now = loop ? ctl_reg[`ULM_CTL_RTS] : ~filt_reg[3]; // R13
  reg [2:0] mprev_reg;
  reg [2:0] mdelta_reg;
  // {cts delta, ring trailing edge, carrier delta}
  wire [2:0] mset;
  // previous level resets inactive: an input held asserted through reset reads as a change
  assign mset[0] = dcd_now ^ mprev_reg[0]; // R14 R15 R16
  assign mset[1] = mprev_reg[1] & ~ring_now; // R17 R18
  assign mset[2] = cts_now ^ mprev_reg[2]; // R21
  wire [2:0] mclr = ms_read ? {prdata_reg[`ULM_MS_CTS_DELTA], prdata_reg[`ULM_MS_RING_TRAIL],
                               prdata_reg[`ULM_MS_DCD_DELTA]} : 3'h0;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mprev_reg <= `ULM_FLAG_RST;
      mdelta_reg <= `ULM_FLAG_RST;
    end else begin
      mprev_reg <= {cts_now, ring_now, dcd_now};
      mdelta_reg <= (mdelta_reg & ~mclr) | mset; // R14 R17 R21 R22
    end
  end

  // ----------------------------------------------------------------
  // register read and write
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000; // R22
    case (sel)
      SEL_RXBUF: rd_mux[7:0] = fifo_en ? mem[rd_ptr_reg][7:0] : rbr_reg;
      SEL_CTRL: rd_mux[`ULM_CTL_W-1:0] = ctl_reg;
      SEL_LS: begin
        rd_mux[`ULM_LS_DATA_READY] = data_ready;
        rd_mux[`ULM_LS_OVERRUN] = ovr_reg;
        rd_mux[`ULM_LS_PARITY_ERR] = lerr_reg[0];
        rd_mux[`ULM_LS_FRAMING_ERR] = lerr_reg[1];
        rd_mux[`ULM_LS_BREAK] = lerr_reg[2];
      end
      SEL_MS: begin
        rd_mux[`ULM_MS_CTS_DELTA] = mdelta_reg[2];
        rd_mux[`ULM_MS_RING_TRAIL] = mdelta_reg[1];
        rd_mux[`ULM_MS_DCD_DELTA] = mdelta_reg[0];
        rd_mux[`ULM_MS_CTS] = cts_now;
        rd_mux[`ULM_MS_RING] = ring_now;
        rd_mux[`ULM_MS_DCD] = dcd_now;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  reg rts_low_reg;
  reg user_output_one_low_reg;
  reg user_output_two_low_reg;
  // one wait state: capture in the first access cycle, side effects on the completing edge
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready_reg <= 1'h0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'h0;
      ctl_reg <= `ULM_CTL_RST;
      rts_low_reg <= 1'h1;
      user_output_one_low_reg <= 1'h1;
      user_output_two_low_reg <= 1'h1;
    end else begin
      pready_reg <= first;
      pslverr_reg <= first & (sel == SEL_NONE);
      if (first) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (ctl_wr) begin
        ctl_reg <= pwdata[`ULM_CTL_W-1:0];
      end
      // in loopback the modem outputs are parked inactive
      rts_low_reg <= loop | ~ctl_reg[`ULM_CTL_RTS];
      user_output_one_low_reg <= loop | ~ctl_reg[`ULM_CTL_USER_OUTPUT_ONE];
      user_output_two_low_reg <= loop | ~ctl_reg[`ULM_CTL_USER_OUTPUT_TWO];
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign rts_out_low = rts_low_reg;
  assign user_user_output_one_low = user_output_one_low_reg;
  assign user_user_output_two_low = user_output_two_low_reg;
endmodule

// ==== sim/ulm_modem_model.sv ====
// modem / data set model driving the serial line and the active-low modem lines
`timescale 1ns/1ns
module ulm_modem_model #(
  parameter DIV = 2
) (
  // clock
  input wire core_clk,
  // lines toward the port, all idle high
  output logic rxd,
  output logic dcd_low,
  output logic ring_low,
  output logic cts_low
);
  localparam int BIT = 16 * DIV;
  // carrier held on from time zero so that it stands across the first reset
  initial begin
    rxd = 1'h1;
    dcd_low = 1'h0;
    ring_low = 1'h1;
    cts_low = 1'h1;
  end
  task automatic lines(input logic d, input logic r, input logic c);
    @(posedge core_clk);
    dcd_low <= d;
    ring_low <= r;
    cts_low <= c;
  endtask
  task automatic hold(input logic v, input int bits);
    @(posedge core_clk);
    rxd <= v;
    repeat (bits * BIT - 1) @(posedge core_clk);
  endtask
  // even parity; bad flips it, a low stop makes a framing fault
  task automatic send(input logic [7:0] d, input logic par, input logic bad, input logic stop);
    hold(1'h0, 1);
    for (int i = 0; i < 8; i++) hold(d[i], 1);
    if (par) hold(^d ^ bad, 1);
    hold(stop, 1);
    hold(1'h1, 2);
  endtask
endmodule

// ==== sim/ulm_status_checker.sv ====
// concurrent assertions on the ports of the line and modem status block
`timescale 1ns/1ns
`include "ulm_defs.vh"
module ulm_status_checker (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // modem lines
  input wire dcd_in_low,
  input wire ring_in_low,
  input wire cts_in_low,
  input wire rts_out_low,
  input wire user_user_output_one_low,
  input wire user_user_output_two_low
);
  logic [3:0] stab;
  logic [2:0] lines_q;
  // loopback forces all modem outputs high, so any low output proves it is off
  wire loop_off = !(rts_out_low && user_user_output_one_low && user_user_output_two_low);
  wire rd_done = pready && !pwrite;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stab <= 4'h0;
      lines_q <= 3'h7;
    end else begin
      lines_q <= {dcd_in_low, ring_in_low, cts_in_low};
      if (lines_q != {dcd_in_low, ring_in_low, cts_in_low}) stab <= 4'h0;
      else if (stab != 4'hF) stab <= stab + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_one_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not on second edge after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr != `ULM_RXBUF_ADDR
    && paddr != `ULM_CTRL_ADDR && paddr != `ULM_LINE_STATUS_ADDR
    && paddr != `ULM_MODEM_STATUS_ADDR))
    else $error("pslverr does not match address decode");
  a_refused_zero: assert property (rd_done && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_holds: assert property (!(psel && penable && !pready) |=> $stable(prdata))
    else $error("prdata changed outside an access capture");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write completed with nonzero prdata");
  a_ls_reserved: assert property (rd_done && paddr == `ULM_LINE_STATUS_ADDR |->
    prdata[31:5] == 27'h0) else $error("line status reserved bits set");
  a_ms_reserved: assert property (rd_done && paddr == `ULM_MODEM_STATUS_ADDR |->
    prdata[31:8] == 24'h0 && !prdata[5] && !prdata[1]) else $error("modem reserved bits set");
  a_modem_levels: assert property (rd_done && paddr == `ULM_MODEM_STATUS_ADDR &&
    stab >= 4'hA && loop_off |-> prdata[7] == !dcd_in_low && prdata[6] == !ring_in_low
    && prdata[4] == !cts_in_low) else $error("modem status levels wrong");
  c_framing: cover property (rd_done && paddr == `ULM_LINE_STATUS_ADDR && prdata[3]);
  c_dcd_delta: cover property (rd_done && paddr == `ULM_MODEM_STATUS_ADDR && prdata[3]);
  c_refused: cover property (pready && pslverr);
endmodule
bind ulm_status ulm_status_checker u_chk (.core_clk(core_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .dcd_in_low(dcd_in_low), .ring_in_low(ring_in_low),
  .cts_in_low(cts_in_low), .rts_out_low(rts_out_low), .user_user_output_one_low(user_user_output_one_low),
  .user_user_output_two_low(user_user_output_two_low));

// ==== sim/ulm_status_bench.sv ====
// self-checking bench for the line and modem status block
`timescale 1ns/1ns
`include "ulm_defs.vh"
module ulm_status_bench;
  logic core_clk, rstn, psel, penable, pwrite, err;
  logic [31:0] paddr, pwdata, rdat;
  wire pready, pslverr, rxd, dcd_low, ring_low, cts_low, rts_low, user_output_one_low, user_output_two_low;
  wire [31:0] prdata;
  int error_cnt = 0;
  int n_tests = 0;
  localparam [31:0] RX = `ULM_RXBUF_ADDR;
  localparam [31:0] CT = `ULM_CTRL_ADDR;
  localparam [31:0] LS = `ULM_LINE_STATUS_ADDR;
  localparam [31:0] MS = `ULM_MODEM_STATUS_ADDR;
  // short bit time keeps the run small: 16 ticks of 2 cycles per bit
  ulm_status #(.SAMPLE_DIV(2), .FIFO_AW(4)) dut (.core_clk(core_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rxd_in(rxd),
    .dcd_in_low(dcd_low), .ring_in_low(ring_low), .cts_in_low(cts_low),
    .rts_out_low(rts_low), .user_user_output_one_low(user_output_one_low), .user_user_output_two_low(user_output_two_low));
  ulm_modem_model #(.DIV(2)) modem (.core_clk(core_clk), .rxd(rxd), .dcd_low(dcd_low),
    .ring_low(ring_low), .cts_low(cts_low));
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    chk("pready", 32'h1, {31'h0, pready});
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk($sformatf("read %h", a), e, rdat);
  endtask
  task automatic settle;
    repeat (12) @(posedge core_clk);
  endtask
  initial begin
    #3_000_000;
    error_cnt++;
    $display("ERROR watchdog exp done got timeout");
    tally_and_finish;
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = 68'h0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'h1;
    settle;
    rd(MS, 32'h88);
    rd(MS, 32'h80);
    rd(LS, 32'h00);
    rd(32'h5000_1108, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'h1, LS, 32'hFF);
    rd(LS, 32'h00);
    apb(1'h1, CT, 32'h04);
    modem.lines(1'h0, 1'h0, 1'h0);
    settle;
    chk("modem outputs", 32'h3, {29'h0, rts_low, user_output_one_low, user_output_two_low});
    modem.lines(1'h0, 1'h1, 1'h0);
    settle;
    rd(MS, 32'h95);
    rd(MS, 32'h90);
    modem.lines(1'h1, 1'h1, 1'h1);
    settle;
    rd(MS, 32'h09);
    rd(MS, 32'h00);
    modem.lines(1'h0, 1'h0, 1'h0);
    settle;
    apb(1'h1, CT, 32'h3C);
    apb(1'h0, MS, 32'h0);
    rd(MS, 32'hD0);
    chk("loop outputs", 32'h7, {29'h0, rts_low, user_output_one_low, user_output_two_low});
    apb(1'h1, CT, 32'h20);
    rd(MS, 32'h0D);
    apb(1'h1, CT, 32'h04);
    modem.lines(1'h1, 1'h1, 1'h1);
    settle;
    apb(1'h0, MS, 32'h0);
    modem.send(8'hA5, 1'h0, 1'h0, 1'h1);
    rd(LS, 32'h01);
    rd(RX, 32'hA5);
    rd(LS, 32'h00);
    modem.send(8'h3C, 1'h0, 1'h0, 1'h1);
    modem.send(8'hC3, 1'h0, 1'h0, 1'h1);
    rd(LS, 32'h03);
    rd(RX, 32'hC3);
    rd(LS, 32'h00);
    modem.send(8'h5A, 1'h0, 1'h0, 1'h0);
    modem.hold(1'h1, 10);
    rd(LS, 32'h0B);
    rd(RX, 32'hFF);
    apb(1'h1, CT, 32'h06);
    modem.send(8'h5A, 1'h1, 1'h1, 1'h1);
    rd(LS, 32'h05);
    rd(RX, 32'h5A);
    modem.send(8'h5B, 1'h1, 1'h0, 1'h1);
    rd(LS, 32'h01);
    rd(RX, 32'h5B);
    modem.hold(1'h0, 20);
    modem.hold(1'h1, 2);
    rd(LS, 32'h1D);
    rd(LS, 32'h01);
    rd(RX, 32'h00);
    apb(1'h1, CT, 32'h07);
    modem.send(8'h11, 1'h1, 1'h0, 1'h1);
    modem.send(8'h22, 1'h1, 1'h1, 1'h1);
    rd(LS, 32'h01);
    rd(RX, 32'h11);
    rd(LS, 32'h05);
    rd(RX, 32'h22);
    rd(LS, 32'h00);
    for (int i = 0; i < 17; i++) modem.send(8'h30 + 8'(i), 1'h1, 1'h0, 1'h1);
    rd(LS, 32'h03);
    for (int i = 0; i < 16; i++) rd(RX, 32'h30 + i);
    rd(LS, 32'h00);
    tally_and_finish;
  end
endmodule
